// [verilog/sfcb_consts.svh]
// register offsets, field positions, reset values and timing counts
`ifndef SFCB_CONSTS_SVH
`define SFCB_CONSTS_SVH

`define SFCB_CLK_HZ      25000000
`define SFCB_STEP_MS     10
`define SFCB_STEP_CYC    (`SFCB_CLK_HZ / 1000 * `SFCB_STEP_MS)

`define SFCB_A_CTRL      6'h00
`define SFCB_A_XON       6'h04
`define SFCB_A_XOFF      6'h08
`define SFCB_A_WXON      6'h0C
`define SFCB_A_RTSOFF    6'h10
`define SFCB_A_OUTW      6'h14
`define SFCB_A_DEPTH     6'h18
`define SFCB_A_STATUS    6'h1C
`define SFCB_A_FRAME     6'h20
`define SFCB_A_ISTAT     6'h24
`define SFCB_A_ICLR      6'h28
`define SFCB_A_IEN       6'h2C
`define SFCB_A_CMD       6'h30

`define SFCB_F_MODE      1:0
`define SFCB_F_IFACE     3:2
`define SFCB_F_DATA8     4
`define SFCB_F_CLRST     5
`define SFCB_F_PROT      6
`define SFCB_F_VALID     31

`define SFCB_XON_RST     8'h11
`define SFCB_XOFF_RST    8'h13
`define SFCB_WXON_RST    16'h00C8
`define SFCB_WXON_MIN    16'h0002
`define SFCB_RTSOFF_RST  16'h0001
`define SFCB_OUTW_RST    16'h0001
`define SFCB_DEPTH_MIN   8'h01
`define SFCB_DEPTH_MAX   8'hFA

`endif

// [verilog/sfcb_pkg.sv]
// types of the flow control and frame buffer block
`default_nettype none
package sfcb_pkg;
	typedef enum logic [1:0] {
		SFCB_NONE   = 2'h0,
		SFCB_XONOFF = 2'h1,
		SFCB_RTSCTS = 2'h2,
		SFCB_AUTO   = 2'h3
	} sfcb_mode_t;

	typedef enum logic [1:0] {
		SFCB_RS232 = 2'h0,
		SFCB_RS422 = 2'h1,
		SFCB_RS485 = 2'h2
	} sfcb_iface_t;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_ASSERT = 5'h02,
		ST_SEND   = 5'h04,
		ST_PAUSE  = 5'h08,
		ST_HOLD   = 5'h10
	} sfcb_tx_t;

	typedef struct packed {
		logic [7:0] rd;
		logic [7:0] wr;
		logic [7:0] cnt;
		logic       drop;
	} sfcb_ring_t;

	typedef struct packed {
		logic [31:0] tick_cnt;
		logic [15:0] timer;
		sfcb_tx_t    st;
		sfcb_mode_t  mode;
		sfcb_iface_t iface;
		logic        data8;
		logic        clr_start;
		logic        prot;
		logic [7:0]  xon;
		logic [7:0]  xoff;
		logic [15:0] wxon;
		logic [15:0] rtsoff;
		logic [15:0] outw;
		logic [7:0]  depth;
		logic [3:0]  istat;
		logic [3:0]  ien;
		logic        cts_s1;
		logic        cts_s2;
		logic        xoff_seen;
		logic        full_d;
		logic        rts;
		logic        go;
		logic        abort;
		logic        fc_send;
		logic [7:0]  fc_char;
		logic        irq;
		logic        ack;
		logic [31:0] rdata;
	} sfcb_regs_t;
endpackage
`default_nettype wire

// [verilog/sfcb_frame_ring.sv]
// ring buffer of complete received frames, oldest delivered first
`default_nettype none
module sfcb_frame_ring #(
	parameter int FRAME_W   = 16,
	parameter int DEPTH_MAX = 250
) (
	input  wire logic               clock_i,
	input  wire logic               rst_n_i,
	input  wire logic               flush_i,
	input  wire logic               push_i,
	input  wire logic [FRAME_W-1:0] data_i,
	input  wire logic               pop_i,
	input  wire logic [7:0]         depth_i,
	input  wire logic               overwrite_i,
	output logic      [FRAME_W-1:0] data_o,
	output logic      [7:0]         count_o,
	output logic                    full_o,
	output logic                    empty_o,
	output logic                    drop_o
);
	import sfcb_pkg::*;

	localparam logic [7:0] LAST = 8'(DEPTH_MAX - 1);

	sfcb_ring_t         r;
	sfcb_ring_t         n;
	logic [FRAME_W-1:0] mem [DEPTH_MAX];
	logic               pop_do;
	logic               space;
	logic               wr_do;
	logic               adv_rd;

	function automatic logic [7:0] nxt(input logic [7:0] p);
		return (p == LAST) ? 8'h00 : p + 8'h01;
	endfunction

	always_comb begin
		n = r;
		pop_do = pop_i && (r.cnt != 8'h00);
		space = (r.cnt < depth_i) || pop_do;
		wr_do = push_i && (space || overwrite_i);
		adv_rd = pop_do || (wr_do && !space);
		n.drop = push_i && !wr_do;
		if (wr_do) begin
			n.wr = nxt(r.wr);
		end
		if (adv_rd) begin
			n.rd = nxt(r.rd);
		end
		n.cnt = r.cnt + {7'h00, wr_do} - {7'h00, adv_rd};
		if (flush_i) begin
			n.rd = 8'h00;
			n.wr = 8'h00;
			n.cnt = 8'h00;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	always_ff @(posedge clock_i) begin
		if (wr_do) begin
			mem[r.wr] <= data_i;
		end
	end

	assign data_o = mem[r.rd];
	assign count_o = r.cnt;
	assign full_o = (r.cnt >= depth_i);
	assign empty_o = (r.cnt == 8'h00);
	assign drop_o = r.drop;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	drop_when_full_a: assert property (
		push_i && full_o && !pop_i && !overwrite_i && !flush_i
		|=> drop_o && (r.cnt == $past(r.cnt)) && (r.wr == $past(r.wr))
	) else $error("full buffer did not discard new frame");

	oldest_first_a: assert property (
		pop_i && !empty_o && !flush_i |=> r.rd == nxt($past(r.rd))
	) else $error("delivery did not advance to next oldest frame");

	overwrite_one_a: assert property (
		push_i && full_o && !pop_i && overwrite_i && !flush_i
		|=> !drop_o && (r.cnt == $past(r.cnt)) && (r.rd == nxt($past(r.rd)))
	) else $error("overwrite did not replace stored frame");
endmodule
`default_nettype wire

// [verilog/sfcb_flow_ctrl.sv]
// flow control pacing, frame buffer and avalon register file
// How it works
// - four flow modes: none, xon/xoff, rts/cts, auto secondary; reset selects none
// - rs485 forbids flow control; rts/cts and auto need rs232
// - resume code programmable, 7 or 8 bit range, reset 11 hex
// - pause code programmable, same range, reset 13 hex
// - wait for resume or cts bounded, 20 ms..655350 ms in 10 ms, reset 2000
// - auto mode: hold time after sending, then rts drops; reset 10 ms
// - auto mode: raise rts, wait up to output wait time for cts
// - each code and time is used only in its own modes
// - start-up command clears buffer or keeps old frames; clearing is default
// - buffer depth 1..250 frames, reset 250
// - overwrite protection on by default, off only at depth one
// - buffer is a ring; host always gets the oldest frame
// - data width 7 or 8 bits limits the flow codes
`include "sfcb_consts.svh"
`default_nettype none
module sfcb_flow_ctrl #(
	parameter int FRAME_W  = 16,
	parameter int TICK_CYC = `SFCB_STEP_CYC
) (
	input  wire logic               clock_i,
	input  wire logic               reset_n_i,
	input  wire logic [5:0]         avs_address_i,
	input  wire logic               avs_read_i,
	input  wire logic               avs_write_i,
	input  wire logic [31:0]        avs_writedata_i,
	output logic      [31:0]        avs_readdata_o,
	output logic                    avs_waitrequest_o,
	input  wire logic               tx_req_i,
	input  wire logic               tx_done_i,
	output logic                    tx_go_o,
	output logic                    tx_abort_o,
	output logic                    fc_send_o,
	output logic      [7:0]         fc_char_o,
	input  wire logic               rx_char_valid_i,
	input  wire logic [7:0]         rx_char_i,
	input  wire logic               rx_frame_valid_i,
	input  wire logic [FRAME_W-1:0] rx_frame_i,
	input  wire logic               cts_i,
	output logic                    rts_o,
	output logic                    irq_o
);
	import sfcb_pkg::*;

	localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);

	logic               rst_s1;
	logic               rst_n;
	sfcb_regs_t         r;
	sfcb_regs_t         n;
	sfcb_mode_t         em;
	logic               tick;
	logic               expire;
	logic               hit_xon;
	logic               hit_xoff;
	logic               resume;
	logic               wr_en;
	logic               rd_en;
	logic               flush;
	logic               pop;
	logic [3:0]         ev;
	logic [3:0]         clr;
	logic [31:0]        rd_v;
	logic [FRAME_W-1:0] rng_data;
	logic [7:0]         rng_cnt;
	logic               rng_full;
	logic               rng_empty;
	logic               rng_drop;

	function automatic logic [7:0] code7(input logic [7:0] c, input logic d8);
		return d8 ? c : {1'b0, c[6:0]};
	endfunction

	function automatic sfcb_mode_t eff_mode(input sfcb_mode_t m, input sfcb_iface_t i);
		if (i == SFCB_RS485) begin
			return SFCB_NONE;
		end else if (i != SFCB_RS232 && (m == SFCB_RTSCTS || m == SFCB_AUTO)) begin
			return SFCB_NONE;
		end
		return m;
	endfunction

	function automatic logic [15:0] at_least(input logic [15:0] v, input logic [15:0] lo);
		return (v < lo) ? lo : v;
	endfunction

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	sfcb_frame_ring #(
		.FRAME_W   (FRAME_W),
		.DEPTH_MAX (int'(`SFCB_DEPTH_MAX))
	) u_ring (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n),
		.flush_i     (flush),
		.push_i      (rx_frame_valid_i),
		.data_i      (rx_frame_i),
		.pop_i       (pop),
		.depth_i     (r.depth),
		.overwrite_i (!r.prot && (r.depth == `SFCB_DEPTH_MIN)),
		.data_o      (rng_data),
		.count_o     (rng_cnt),
		.full_o      (rng_full),
		.empty_o     (rng_empty),
		.drop_o      (rng_drop)
	);

	always_comb begin
		n = r;
		em = eff_mode(r.mode, r.iface);
		n.cts_s1 = cts_i;
		n.cts_s2 = r.cts_s1;
		// bus slave: one wait state, transfer completes at the ack edge
		n.ack = (avs_read_i || avs_write_i) && !r.ack;
		wr_en = avs_write_i && r.ack;
		rd_en = avs_read_i && r.ack;
		pop = rd_en && (avs_address_i == `SFCB_A_FRAME) && !rng_empty;
		flush = 1'b0;
		clr = 4'h0;
		rd_v = 32'h0000_0000;
		unique case (avs_address_i)
			`SFCB_A_CTRL: rd_v = {25'h0, r.prot, r.clr_start, r.data8, r.iface, r.mode};
			`SFCB_A_XON: rd_v = {24'h0, r.xon};
			`SFCB_A_XOFF: rd_v = {24'h0, r.xoff};
			`SFCB_A_WXON: rd_v = {16'h0, r.wxon};
			`SFCB_A_RTSOFF: rd_v = {16'h0, r.rtsoff};
			`SFCB_A_OUTW: rd_v = {16'h0, r.outw};
			`SFCB_A_DEPTH: rd_v = {24'h0, r.depth};
			`SFCB_A_STATUS: rd_v = {14'h0, em, r.xoff_seen, r.cts_s2, r.rts, r.st, rng_cnt};
			`SFCB_A_FRAME: rd_v = rng_empty ? 32'h0000_0000 : {1'b1, 31'(rng_data)};
			`SFCB_A_ISTAT: rd_v = {28'h0, r.istat};
			`SFCB_A_IEN: rd_v = {28'h0, r.ien};
			default: rd_v = 32'h0000_0000;
		endcase
		if (n.ack) begin
			n.rdata = rd_v;
		end
		if (wr_en) begin
			unique case (avs_address_i)
				`SFCB_A_CTRL: begin
					n.mode = sfcb_mode_t'(avs_writedata_i[`SFCB_F_MODE]);
					n.iface = sfcb_iface_t'(avs_writedata_i[`SFCB_F_IFACE]);
					n.data8 = avs_writedata_i[`SFCB_F_DATA8];
					n.clr_start = avs_writedata_i[`SFCB_F_CLRST];
					n.prot = avs_writedata_i[`SFCB_F_PROT];
				end
				`SFCB_A_XON: n.xon = code7(avs_writedata_i[7:0], r.data8);
				`SFCB_A_XOFF: n.xoff = code7(avs_writedata_i[7:0], r.data8);
				`SFCB_A_WXON: n.wxon = at_least(avs_writedata_i[15:0], `SFCB_WXON_MIN);
				`SFCB_A_RTSOFF: n.rtsoff = avs_writedata_i[15:0];
				`SFCB_A_OUTW: n.outw = avs_writedata_i[15:0];
				`SFCB_A_DEPTH: begin
					if (avs_writedata_i[7:0] < `SFCB_DEPTH_MIN) begin
						n.depth = `SFCB_DEPTH_MIN;
					end else if (avs_writedata_i[7:0] > `SFCB_DEPTH_MAX) begin
						n.depth = `SFCB_DEPTH_MAX;
					end else begin
						n.depth = avs_writedata_i[7:0];
					end
				end
				`SFCB_A_ICLR: clr = avs_writedata_i[3:0];
				`SFCB_A_IEN: n.ien = avs_writedata_i[3:0];
				`SFCB_A_CMD: flush = avs_writedata_i[0] && r.clr_start;
				default: n.ien = r.ien;
			endcase
		end
		// 10 ms step timer, restarted on every load
		tick = (r.tick_cnt == TICK_LAST);
		n.tick_cnt = tick ? 32'h0 : r.tick_cnt + 32'h1;
		if (tick && r.timer != 16'h0) begin
			n.timer = r.timer - 16'h1;
		end
		expire = (r.timer == 16'h0);
		// pause and resume codes matter only in xon/xoff mode
		hit_xon = rx_char_valid_i && code7(rx_char_i, r.data8) == code7(r.xon, r.data8);
		hit_xoff = rx_char_valid_i && code7(rx_char_i, r.data8) == code7(r.xoff, r.data8);
		if (em != SFCB_XONOFF) begin
			n.xoff_seen = 1'b0;
		end else if (hit_xoff) begin
			n.xoff_seen = 1'b1;
		end else if (hit_xon) begin
			n.xoff_seen = 1'b0;
		end
		resume = (em == SFCB_XONOFF) ? !n.xoff_seen : r.cts_s2;
		ev = 4'h0;
		n.abort = 1'b0;
		unique case (r.st)
			ST_IDLE: begin
				n.rts = 1'b0;
				if (tx_req_i) begin
					if (em == SFCB_AUTO) begin
						n.rts = 1'b1;
						n.timer = r.outw;
						n.tick_cnt = 32'h0;
						n.st = ST_ASSERT;
					end else if (em != SFCB_NONE && !resume) begin
						n.timer = r.wxon;
						n.tick_cnt = 32'h0;
						n.st = ST_PAUSE;
					end else begin
						n.st = ST_SEND;
					end
				end
			end
			ST_ASSERT: begin
				if (r.cts_s2) begin
					n.st = ST_SEND;
				end else if (expire) begin
					n.abort = 1'b1;
					n.rts = 1'b0;
					n.st = ST_IDLE;
				end
			end
			ST_SEND: begin
				if (tx_done_i) begin
					ev[3] = 1'b1;
					if (em == SFCB_AUTO) begin
						n.timer = r.rtsoff;
						n.tick_cnt = 32'h0;
						n.st = ST_HOLD;
					end else begin
						n.st = ST_IDLE;
					end
				end else if ((em == SFCB_XONOFF || em == SFCB_RTSCTS) && !resume) begin
					n.timer = r.wxon;
					n.tick_cnt = 32'h0;
					n.st = ST_PAUSE;
				end
			end
			ST_PAUSE: begin
				if (resume) begin
					n.st = ST_SEND;
				end else if (expire) begin
					n.abort = 1'b1;
					n.st = ST_IDLE;
				end
			end
			ST_HOLD: begin
				if (expire) begin
					n.rts = 1'b0;
					n.st = ST_IDLE;
				end
			end
			default: n.st = ST_IDLE;
		endcase
		if (em == SFCB_RTSCTS) begin
			n.rts = !rng_full;
		end else if (em != SFCB_AUTO) begin
			n.rts = 1'b0;
		end
		n.go = (n.st == ST_SEND);
		// own buffer filling or draining sends pause or resume
		n.full_d = rng_full;
		n.fc_send = (em == SFCB_XONOFF) && (rng_full != r.full_d);
		n.fc_char = code7(rng_full ? r.xoff : r.xon, r.data8);
		ev[0] = rx_frame_valid_i;
		ev[1] = rng_drop;
		ev[2] = n.abort;
		n.istat = (r.istat & ~clr) | ev;
		n.irq = |(n.istat & n.ien);
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.mode <= SFCB_NONE;
			r.iface <= SFCB_RS232;
			r.data8 <= 1'b1;
			r.clr_start <= 1'b1;
			r.prot <= 1'b1;
			r.xon <= `SFCB_XON_RST;
			r.xoff <= `SFCB_XOFF_RST;
			r.wxon <= `SFCB_WXON_RST;
			r.rtsoff <= `SFCB_RTSOFF_RST;
			r.outw <= `SFCB_OUTW_RST;
			r.depth <= `SFCB_DEPTH_MAX;
		end else begin
			r <= n;
		end
	end

	assign avs_readdata_o = r.rdata;
	assign avs_waitrequest_o = !r.ack;
	assign tx_go_o = r.go;
	assign tx_abort_o = r.abort;
	assign fc_send_o = r.fc_send;
	assign fc_char_o = r.fc_char;
	assign rts_o = r.rts;
	assign irq_o = r.irq;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n);

	sequence s_auto_req;
		r.st == ST_IDLE && tx_req_i && em == SFCB_AUTO;
	endsequence

	sequence s_rts_waiting;
		rts_o && !tx_go_o && r.st == ST_ASSERT;
	endsequence

	no_flow_485_a: assert property (r.iface == SFCB_RS485 |-> em == SFCB_NONE)
		else $error("flow control active on two-wire interface");

	auto_rts_up_a: assert property (s_auto_req |=> s_rts_waiting)
		else $error("auto mode did not raise rts and wait");

	pause_stops_a: assert property (
		r.st == ST_SEND && em == SFCB_XONOFF && hit_xoff && !tx_done_i
		|=> !tx_go_o && r.st == ST_PAUSE
	) else $error("pause character did not suspend sending");

	wait_abort_a: assert property (
		r.st == ST_PAUSE && expire && !resume |=> tx_abort_o && !tx_go_o ##1 !tx_abort_o
	) else $error("resume wait expiry did not abort once");

	wait_min_a: assert property (r.wxon >= `SFCB_WXON_MIN)
		else $error("resume wait below minimum");

	hold_release_a: assert property (
		r.st == ST_HOLD && expire |=> !rts_o && r.st == ST_IDLE
	) else $error("rts not released after hold time");

	depth_range_a: assert property (
		r.depth >= `SFCB_DEPTH_MIN && r.depth <= `SFCB_DEPTH_MAX
	) else $error("buffer depth out of range");

	code_width_a: assert property (fc_send_o && !r.data8 |-> !fc_char_o[7])
		else $error("flow code exceeds seven data bits");

	bus_answer_a: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o
	) else $error("bus request not answered in one cycle");
endmodule
`default_nettype wire

// [sim/sfcb_partner.sv]
// remote serial partner: answers rts with cts, sends and collects flow chars
`default_nettype none
module sfcb_partner (
	input  wire logic       clock_i,
	input  wire logic       rts_i,
	input  wire logic       fc_send_i,
	input  wire logic [7:0] fc_char_i,
	input  wire logic [3:0] lag_i,
	output logic            cts_o,
	output logic            char_valid_o,
	output logic [7:0]      char_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] n       = 4'h0;
	logic [7:0] last_fc = 8'h00;
	int         fc_cnt  = 0;
	initial begin
		cts_o = 1'b0;
		char_valid_o = 1'b0;
		char_o = 8'h00;
	end
	// cts follows rts after lag_i+1 cycles; lag 0 never answers
	always @(posedge clock_i) begin
		if (!rts_i || lag_i == 4'h0) begin
			n <= 4'h0;
			cts_o <= 1'b0;
		end else if (n < lag_i) begin
			n <= n + 4'h1;
		end else begin
			cts_o <= 1'b1;
		end
		if (fc_send_i) begin
			last_fc <= fc_char_i;
			fc_cnt <= fc_cnt + 1;
		end
	end
	// one character on the line; afterwards the line shows its inverse
	task automatic send_char(input logic [7:0] c);
		@(posedge clock_i);
		char_valid_o <= 1'b1;
		char_o <= c;
		@(posedge clock_i);
		char_valid_o <= 1'b0;
		char_o <= ~c;
	endtask
endmodule
`default_nettype wire

// [sim/tb_sfcb_flow_ctrl.sv]
// self-checking bench: registers, pacing modes and frame ring
`default_nettype none
`include "sfcb_consts.svh"
module tb_sfcb_flow_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import sfcb_pkg::*;
	localparam int TK = 8;
	logic        clock_i   = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [5:0]  adr       = 6'h00;
	logic        rd_s      = 1'b0;
	logic        wr_s      = 1'b0;
	logic [31:0] wdat      = 32'h0;
	logic        req       = 1'b0;
	logic        done      = 1'b0;
	logic        fv        = 1'b0;
	logic [15:0] fd        = 16'h0;
	logic [3:0]  lag       = 4'h2;
	logic [31:0] rdat;
	logic [31:0] q;
	logic        wreq, go, abt, fcs, rts, cts, irq, cv;
	logic [7:0]  fcc, ch;
	int          failures        = 0;
	int          samples_checked = 0;
	int          ticks           = 0;
	int          k;

	sfcb_flow_ctrl #(.FRAME_W(16), .TICK_CYC(TK)) sfcb_flow_ctrl_i (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .avs_address_i(adr),
		.avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .tx_req_i(req),
		.tx_done_i(done), .tx_go_o(go), .tx_abort_o(abt), .fc_send_o(fcs),
		.fc_char_o(fcc), .rx_char_valid_i(cv), .rx_char_i(ch),
		.rx_frame_valid_i(fv), .rx_frame_i(fd), .cts_i(cts), .rts_o(rts), .irq_o(irq));
	sfcb_partner sfcb_partner_i (
		.clock_i(clock_i), .rts_i(rts), .fc_send_i(fcs), .fc_char_i(fcc),
		.lag_i(lag), .cts_o(cts), .char_valid_o(cv), .char_o(ch));

	always #20 clock_i = ~clock_i;

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge clock_i) begin
		ticks <= ticks + 1;
		if (ticks == 20000) begin
			failures++;
			report_and_stop();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	// avalon access: hold until waitrequest sampled low
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_i);
		rd_s <= !w;
		wr_s <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clock_i);
			n++;
		end while (wreq !== 1'b0 && n < 100);
		if (n >= 100) failures++;
		q = rdat;
		rd_s <= 1'b0;
		wr_s <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rc(input string n, input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(n, q, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// 0 send request, 1 send done, 2 frame store
	task automatic pulse(input int w, input logic [15:0] f);
		@(posedge clock_i);
		req <= (w == 0);
		done <= (w == 1);
		fv <= (w == 2);
		fd <= f;
		@(posedge clock_i);
		req <= 1'b0;
		done <= 1'b0;
		fv <= 1'b0;
		fd <= ~f;
	endtask
	task automatic wabt(output int n);
		n = 0;
		while (abt !== 1'b1 && n < 200) begin
			@(posedge clock_i);
			n++;
		end
	endtask
	function automatic logic [1:0] emode(input logic [3:0] c);
		return (c[3:2] == SFCB_RS485 || (c[3:2] == SFCB_RS422 && c[1])) ? SFCB_NONE : c[1:0];
	endfunction

	initial begin
		repeat (20) @(posedge clock_i);
		reset_n_i <= 1'b1;
		cyc(4);
		rc("ctrl", `SFCB_A_CTRL, 32'h70);
		rc("xon", `SFCB_A_XON, 32'h11);
		rc("xoff", `SFCB_A_XOFF, 32'h13);
		rc("wxon", `SFCB_A_WXON, 32'hC8);
		rc("rtsoff", `SFCB_A_RTSOFF, 32'h1);
		rc("outw", `SFCB_A_OUTW, 32'h1);
		rc("depth", `SFCB_A_DEPTH, 32'hFA);
		rc("ien", `SFCB_A_IEN, 32'h0);
		rc("istat", `SFCB_A_ISTAT, 32'h0);
		rc("unmapped", 6'h3C, 32'h0);
		wr(`SFCB_A_WXON, 32'h1);
		rc("wxon min", `SFCB_A_WXON, 32'h2);
		wr(`SFCB_A_DEPTH, 32'h0);
		rc("depth min", `SFCB_A_DEPTH, 32'h1);
		wr(`SFCB_A_DEPTH, 32'hFF);
		rc("depth max", `SFCB_A_DEPTH, 32'hFA);
		wr(`SFCB_A_CTRL, 32'h60);
		wr(`SFCB_A_XON, 32'hFF);
		rc("xon 7 bit", `SFCB_A_XON, 32'h7F);
		wr(`SFCB_A_CTRL, 32'h70);
		wr(`SFCB_A_XOFF, 32'hFF);
		rc("xoff 8 bit", `SFCB_A_XOFF, 32'hFF);
		wr(`SFCB_A_XON, 32'h11);
		wr(`SFCB_A_XOFF, 32'h13);
		for (int i = 0; i < 12; i++) begin
			wr(`SFCB_A_CTRL, 32'h70 | 32'(i));
			bus(1'b0, `SFCB_A_STATUS, 32'h0);
			chk("eff mode", q[17:16], emode(4'(i)));
		end
		// mode none ignores a pause character
		wr(`SFCB_A_CTRL, 32'h70);
		pulse(0, 16'h0);
		cyc(2);
		chk("go none", go, 1'b1);
		sfcb_partner_i.send_char(8'h13);
		cyc(3);
		chk("go no pause", go, 1'b1);
		pulse(1, 16'h0);
		cyc(2);
		chk("go end", go, 1'b0);
		// xon/xoff: pause, resume, then pause timeout
		wr(`SFCB_A_CTRL, 32'h71);
		wr(`SFCB_A_IEN, 32'h4);
		pulse(0, 16'h0);
		cyc(2);
		chk("go xon", go, 1'b1);
		sfcb_partner_i.send_char(8'h13);
		cyc(3);
		chk("go paused", go, 1'b0);
		bus(1'b0, `SFCB_A_STATUS, 32'h0);
		chk("pause state", q[15:8], 8'h88);
		sfcb_partner_i.send_char(8'h11);
		cyc(4);
		chk("go resumed", go, 1'b1);
		sfcb_partner_i.send_char(8'h13);
		wabt(k);
		chk("pause wait", k > 12 && k < 24, 1'b1);
		cyc(2);
		chk("irq abort", irq, 1'b1);
		bus(1'b0, `SFCB_A_ISTAT, 32'h0);
		chk("istat abort", q[2], 1'b1);
		wr(`SFCB_A_ICLR, 32'h4);
		cyc(2);
		chk("irq cleared", irq, 1'b0);
		// rts/cts: silent partner times out, answering partner releases
		wr(`SFCB_A_CTRL, 32'h72);
		lag <= 4'h0;
		pulse(0, 16'h0);
		wabt(k);
		chk("cts wait", k > 12 && k < 24, 1'b1);
		lag <= 4'h2;
		cyc(6);
		pulse(0, 16'h0);
		cyc(2);
		chk("go cts", go, 1'b1);
		pulse(1, 16'h0);
		// auto secondary signals
		wr(`SFCB_A_CTRL, 32'h73);
		wr(`SFCB_A_RTSOFF, 32'h2);
		wr(`SFCB_A_OUTW, 32'h3);
		pulse(0, 16'h0);
		cyc(1);
		chk("rts up", rts, 1'b1);
		chk("go waits cts", go, 1'b0);
		cyc(8);
		chk("go auto", go, 1'b1);
		pulse(1, 16'h0);
		cyc(10);
		chk("rts hold", rts, 1'b1);
		cyc(10);
		chk("rts off", rts, 1'b0);
		lag <= 4'h0;
		pulse(0, 16'h0);
		wabt(k);
		chk("outw wait", k > 20 && k < 32, 1'b1);
		cyc(2);
		chk("rts dropped", rts, 1'b0);
		// protected ring of three in xon/xoff mode, seven data bits
		wr(`SFCB_A_CTRL, 32'h61);
		wr(`SFCB_A_DEPTH, 32'h3);
		wr(`SFCB_A_IEN, 32'h2);
		for (int i = 1; i < 5; i++) pulse(2, 16'(i));
		cyc(3);
		chk("irq drop", irq, 1'b1);
		bus(1'b0, `SFCB_A_STATUS, 32'h0);
		chk("count", q[7:0], 8'h03);
		bus(1'b0, `SFCB_A_ISTAT, 32'h0);
		chk("istat drop", q[1], 1'b1);
		chk("pause sent", sfcb_partner_i.last_fc, 8'h13);
		for (int i = 1; i < 4; i++) rc("frame", `SFCB_A_FRAME, 32'h80000000 | i);
		rc("empty", `SFCB_A_FRAME, 32'h0);
		chk("resume sent", sfcb_partner_i.last_fc, 8'h11);
		chk("fc count", sfcb_partner_i.fc_cnt, 2);
		// overwrite only at depth one; frame event masked
		wr(`SFCB_A_ICLR, 32'hF);
		wr(`SFCB_A_CTRL, 32'h30);
		wr(`SFCB_A_DEPTH, 32'h1);
		pulse(2, 16'hA1A1);
		pulse(2, 16'hB2B2);
		cyc(2);
		chk("irq masked", irq, 1'b0);
		rc("overwrite", `SFCB_A_FRAME, 32'h8000B2B2);
		wr(`SFCB_A_DEPTH, 32'h2);
		for (int i = 1; i < 4; i++) pulse(2, 16'(i));
		rc("no ow 1", `SFCB_A_FRAME, 32'h80000001);
		rc("no ow 2", `SFCB_A_FRAME, 32'h80000002);
		// start-up command keeps or clears
		wr(`SFCB_A_CTRL, 32'h50);
		pulse(2, 16'h5A5A);
		wr(`SFCB_A_CMD, 32'h1);
		rc("kept", `SFCB_A_FRAME, 32'h80005A5A);
		wr(`SFCB_A_CTRL, 32'h70);
		pulse(2, 16'h6B6B);
		wr(`SFCB_A_CMD, 32'h1);
		rc("cleared", `SFCB_A_FRAME, 32'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
